//--- src/pcu_map.vh
// Operation
// RULE_01: execution condition low leaves results untouched
// RULE_02: issuer keeps each lower limit within upper
// RULE_03: block compare tests sixteen limit pairs inclusively
// RULE_04: value outside pair clears its result bit
// RULE_05: block past area end raises fault
// RULE_06: issuer keeps sixteen-word table inside area
// RULE_07: table match sets bit n, others cleared
// RULE_08: table past area end raises fault
// RULE_09: no table match sets the same flag
// RULE_10: range compare sets exactly below, same, above
// RULE_11: flags sit at special bits 25505 to 25507
// RULE_12: range compare faults when lower exceeds upper
// RULE_13: every compare refreshes flags; issuer samples promptly; block compare leaves all flags as they were, table refreshes only same
// RULE_14: double range compare uses high/low word pairs
// RULE_15: issuer keeps double operands ordered and contained
// RULE_16: signed compare orders two's complement sixteen-bit words
// RULE_17: issuer codes signed compare third field 000
// RULE_18: bad indirect pointer raises fault on every compare
// RULE_19: faulted compare leaves result and flags unchanged
`ifndef PCU_MAP_VH
`define PCU_MAP_VH

// apb register byte offsets
`define PCU_OFS_CTRL 12'h000
`define PCU_OFS_STATUS 12'h004
`define PCU_OFS_CVAL 12'h008
`define PCU_OFS_LOWER 12'h00C
`define PCU_OFS_UPPER 12'h010
`define PCU_OFS_ADDR 12'h014
`define PCU_OFS_RESULT 12'h018
// data memory window select, paddr[11:10]
`define PCU_MEM_SEL 2'h1

// control register fields
`define PCU_CTRL_GO 0
`define PCU_CTRL_EXEC 1
`define PCU_CTRL_OP_LO 2
`define PCU_CTRL_OP_HI 4
`define PCU_CTRL_IND 5

// status register fields; flag bits mirror special word 255 bits 05..07
`define PCU_ST_BUSY 0
`define PCU_ST_FAULT 4
`define PCU_ST_ABOVE 5
`define PCU_ST_SAME 6
`define PCU_ST_BELOW 7
`define PCU_SPECIAL_WORD 16'h00FF
`define PCU_ABOVE_BITADDR 16'h63A1
`define PCU_SAME_BITADDR 16'h63A2
`define PCU_BELOW_BITADDR 16'h63A3

// operation codes
`define PCU_OP_BLOCK 3'h0
`define PCU_OP_TABLE 3'h1
`define PCU_OP_RANGE 3'h2
`define PCU_OP_DRANGE 3'h3
`define PCU_OP_SIGNED 3'h4

// data area geometry
`define PCU_AREA_LAST 14'h00FF
`define PCU_BLOCK_SPAN 9'h01F
`define PCU_TABLE_SPAN 9'h00F
`define PCU_PAIR_SPAN 9'h001
`define PCU_NO_SPAN 9'h000
// last fetch index of the run state per operation
`define PCU_BLOCK_LAST 5'h1F
`define PCU_TABLE_LAST 5'h0F

// reset values
`define PCU_RST_WORD 32'h00000000
`define PCU_RST_HALF 16'h0000
`define PCU_RST_ADDR 8'h00

`endif

//--- src/pcu_bcd_ptr.v
`timescale 1ns/100ps
// four-digit bcd pointer to binary word index
module pcu_bcd_ptr (
   input wire [15:0] ptr_word_i,
   output wire ptr_valid_o,
   output wire [13:0] ptr_index_o
);
   wire [13:0] d3;
   wire [13:0] d2;
   wire [13:0] d1;
   wire [13:0] d0;

   // widen digits so the weighted sum never overflows 9999
   assign d3 = {10'h000, ptr_word_i[15:12]};
   assign d2 = {10'h000, ptr_word_i[11:8]};
   assign d1 = {10'h000, ptr_word_i[7:4]};
   assign d0 = {10'h000, ptr_word_i[3:0]};

   // every nibble must be a decimal digit
   assign ptr_valid_o = (ptr_word_i[15:12] <= 4'h9) && (ptr_word_i[11:8] <= 4'h9) &&
                        (ptr_word_i[7:4] <= 4'h9) && (ptr_word_i[3:0] <= 4'h9);
   assign ptr_index_o = d3 * 14'h03E8 + d2 * 14'h0064 + d1 * 14'h000A + d0;
endmodule

//--- src/pcu_top.v
`timescale 1ns/100ps
`include "pcu_map.vh"
module pcu_top (
   input wire mclk_i,
   input wire sys_rst_i,
   input wire [11:0] paddr_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   output wire above_flag_o,
   output wire same_flag_o,
   output wire below_flag_o,
   output wire fault_flag_o,
   output wire busy_o,
   output wire [15:0] result_o
);
   localparam S_IDLE = 2'h0;
   localparam S_RESOLVE = 2'h1;
   localparam S_CHECK = 2'h2;
   localparam S_RUN = 2'h3;

   // data memory area, written only from the bus
   reg [15:0] mem [0:255];

   reg [1:0] state_r;
   reg [2:0] op_r;
   reg ind_r;
   reg [7:0] base_r;
   reg [4:0] idx_r;
   reg [15:0] lo_r;
   reg [15:0] acc_r;
   reg [15:0] result_r;
   reg above_r;
   reg same_r;
   reg below_r;
   reg fault_r;
   reg [31:0] cval_r;
   reg [31:0] lower_r;
   reg [31:0] upper_r;
   reg [7:0] addr_r;
   reg [2:0] ctrl_op_r;
   reg ctrl_ind_r;
   reg ctrl_exec_r;
   reg pready_r;
   reg pslverr_r;
   reg [31:0] prdata_r;
   reg [15:0] acc_upd;
   reg [8:0] span;
   reg [31:0] rd_word;
   reg rd_hit;

   wire acc_phase;
   wire wr_take;
   wire mem_hit;
   wire go_req;
   wire [15:0] ptr_word;
   wire ptr_valid;
   wire [13:0] ptr_index;
   wire [7:0] run_addr;
   wire [15:0] run_word;
   wire [7:0] base_hi;
   wire [31:0] dcv;
   wire [15:0] cv16;
   wire [15:0] sop_a;
   wire [15:0] sop_b;
   wire [8:0] span_end;

   // decoded conditions, kept apart so the sequencer reads as plain steps
   wire cv_from_mem;
   wire acc_first;
   wire run_last;
   wire go_take;
   wire ptr_bad;
   wire op_bad;
   wire span_bad;
   wire lim_bad;
   wire dlim_bad;
   wire [31:0] ctrl_word;
   wire [31:0] status_word;

   // two-cycle apb access: data is registered, so pready comes one cycle late
   assign acc_phase = psel_i && penable_i;
   assign acc_first = acc_phase && !pready_r;
   assign wr_take = acc_phase && pready_r && pwrite_i;
   assign mem_hit = (paddr_i[11:10] == `PCU_MEM_SEL);
   assign go_req = wr_take && (paddr_i == `PCU_OFS_CTRL) && pwdata_i[`PCU_CTRL_GO];
   // only looked at in S_IDLE, so a go written while busy is dropped
   assign go_take = go_req && pwdata_i[`PCU_CTRL_EXEC];

   // pointer word is always fetched from the programmed address
   assign ptr_word = mem[addr_r];

   pcu_bcd_ptr u_ptr (
      .ptr_word_i(ptr_word),
      .ptr_valid_o(ptr_valid),
      .ptr_index_o(ptr_index)
   );

   // operand words for the sequencer
   assign run_addr = base_r + {3'h0, idx_r};
   assign run_word = mem[run_addr];
   assign base_hi = base_r + 8'h01;
   // indirect operands come from memory, high word holds the upper digits
   assign dcv = ind_r ? {mem[base_hi], mem[base_r]} : cval_r; // see RULE_14
   // when indirect, range, double range and signed take their value from memory; block and table keep cval
   assign cv_from_mem = ind_r && (op_r > `PCU_OP_TABLE);
   assign cv16 = cv_from_mem ? mem[base_r] : cval_r[15:0];
   assign sop_a = cv16;
   assign sop_b = upper_r[15:0];
   assign span_end = {1'b0, base_r} + span;

   // fault sources; each one ends the op before any result or flag is written
   assign ptr_bad = !ptr_valid || (ptr_index > `PCU_AREA_LAST);
   assign op_bad = (op_r > `PCU_OP_SIGNED);
   assign span_bad = span_end[8];
   assign lim_bad = (lower_r[15:0] > upper_r[15:0]);
   assign dlim_bad = (lower_r > upper_r);
   // last fetch of block or table; bounds the run state
   assign run_last = (op_r == `PCU_OP_BLOCK) ? (idx_r == `PCU_BLOCK_LAST) :
                     (idx_r == `PCU_TABLE_LAST);

   // span of memory touched beyond the base, per operation
   always @* begin
      case (op_r)
         `PCU_OP_BLOCK: span = `PCU_BLOCK_SPAN;
         `PCU_OP_TABLE: span = `PCU_TABLE_SPAN;
         `PCU_OP_DRANGE: span = ind_r ? `PCU_PAIR_SPAN : `PCU_NO_SPAN;
         default: span = `PCU_NO_SPAN;
      endcase
   end

   // accumulated result with the bit of this cycle folded in
   always @* begin
      acc_upd = acc_r;
      if (op_r == `PCU_OP_BLOCK) begin
         if (idx_r[0]) begin
            // inclusive pair test; outside the pair the bit is cleared
            acc_upd[idx_r[4:1]] = (cv16 >= lo_r) && (cv16 <= run_word); // see RULE_03 RULE_04
         end
      end else begin
         acc_upd[idx_r[3:0]] = (cv16 == run_word); // see RULE_07
      end
   end

   // compare sequencer and result flags
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state_r <= S_IDLE;
         op_r <= 3'h0;
         ind_r <= 1'b0;
         base_r <= `PCU_RST_ADDR;
         idx_r <= 5'h00;
         lo_r <= `PCU_RST_HALF;
         acc_r <= `PCU_RST_HALF;
         result_r <= `PCU_RST_HALF;
         above_r <= 1'b0;
         same_r <= 1'b0;
         below_r <= 1'b0;
         fault_r <= 1'b0;
      end else begin
         case (state_r)
            S_IDLE: begin
               // nothing moves unless the execution condition is on
               if (go_take) begin // see RULE_01
                  op_r <= pwdata_i[`PCU_CTRL_OP_HI:`PCU_CTRL_OP_LO];
                  ind_r <= pwdata_i[`PCU_CTRL_IND];
                  fault_r <= 1'b0;
                  idx_r <= 5'h00;
                  acc_r <= `PCU_RST_HALF;
                  state_r <= S_RESOLVE;
               end
            end
            S_RESOLVE: begin
               if (!ind_r) begin
                  // direct base is taken as written
                  base_r <= addr_r;
                  state_r <= S_CHECK;
               end else if (ptr_bad) begin
                  // non-bcd or out-of-area pointer aborts the compare
                  fault_r <= 1'b1; // see RULE_18 RULE_19
                  state_r <= S_IDLE;
               end else begin
                  base_r <= ptr_index[7:0];
                  state_r <= S_CHECK;
               end
            end
            S_CHECK: begin
               if (op_bad) begin
                  // undefined operation code is refused as a fault
                  fault_r <= 1'b1;
                  state_r <= S_IDLE;
               end else if (span_bad) begin
                  // block, table or word pair runs off the area end
                  fault_r <= 1'b1; // see RULE_05 RULE_08 RULE_19
                  state_r <= S_IDLE;
               end else begin
                  state_r <= S_RUN;
               end
            end
            S_RUN: begin
               case (op_r)
                  `PCU_OP_BLOCK, `PCU_OP_TABLE: begin
                     // one memory word per cycle
                     // block and table leave above and below alone
                     if (!idx_r[0] && (op_r == `PCU_OP_BLOCK)) begin
                        lo_r <= run_word;
                     end
                     acc_r <= acc_upd;
                     if (run_last) begin
                        result_r <= acc_upd;
                        if (op_r == `PCU_OP_TABLE) begin
                           same_r <= (acc_upd == `PCU_RST_HALF); // see RULE_09
                        end
                        state_r <= S_IDLE;
                     end else begin
                        idx_r <= idx_r + 5'h01;
                     end
                  end
                  `PCU_OP_RANGE: begin
                     if (lim_bad) begin
                        fault_r <= 1'b1; // see RULE_12 RULE_19
                     end else begin
                        // exactly one flag, refreshed on each compare
                        below_r <= (cv16 < lower_r[15:0]); // see RULE_10 RULE_11 RULE_13
                        same_r <= (cv16 >= lower_r[15:0]) && (cv16 <= upper_r[15:0]);
                        above_r <= (cv16 > upper_r[15:0]);
                     end
                     state_r <= S_IDLE;
                  end
                  `PCU_OP_DRANGE: begin
                     // full 32-bit unsigned ordering of the joined word pairs
                     if (dlim_bad) begin
                        fault_r <= 1'b1; // see RULE_14 RULE_19
                     end else begin
                        below_r <= (dcv < lower_r); // see RULE_14 RULE_11
                        same_r <= (dcv >= lower_r) && (dcv <= upper_r);
                        above_r <= (dcv > upper_r);
                     end
                     state_r <= S_IDLE;
                  end
                  default: begin
                     // two's complement ordering of the two words
                     below_r <= ($signed(sop_a) < $signed(sop_b)); // see RULE_16 RULE_11
                     same_r <= (sop_a == sop_b);
                     above_r <= ($signed(sop_a) > $signed(sop_b));
                     state_r <= S_IDLE;
                  end
               endcase
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   // software-written operand and control registers
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         cval_r <= `PCU_RST_WORD;
         lower_r <= `PCU_RST_WORD;
         upper_r <= `PCU_RST_WORD;
         addr_r <= `PCU_RST_ADDR;
         ctrl_op_r <= 3'h0;
         ctrl_ind_r <= 1'b0;
         ctrl_exec_r <= 1'b0;
      end else if (wr_take) begin
         case (paddr_i)
            `PCU_OFS_CTRL: begin
               ctrl_op_r <= pwdata_i[`PCU_CTRL_OP_HI:`PCU_CTRL_OP_LO];
               ctrl_ind_r <= pwdata_i[`PCU_CTRL_IND];
               ctrl_exec_r <= pwdata_i[`PCU_CTRL_EXEC];
            end
            `PCU_OFS_CVAL: cval_r <= pwdata_i;
            `PCU_OFS_LOWER: lower_r <= pwdata_i;
            `PCU_OFS_UPPER: upper_r <= pwdata_i;
            `PCU_OFS_ADDR: addr_r <= pwdata_i[7:0];
            default: begin
               // status, result and unmapped writes are dropped
            end
         endcase
      end
   end

   // memory writes; no reset, contents are software's business
   always @(posedge mclk_i) begin
      if (wr_take && mem_hit) begin
         mem[paddr_i[9:2]] <= pwdata_i[15:0];
      end
   end

   // register images; go is a pulse and always reads back as zero
   assign ctrl_word = {26'h0, ctrl_ind_r, ctrl_op_r, ctrl_exec_r, 1'b0};
   assign status_word = {24'h000000, below_r, same_r, above_r, fault_r,
                         3'h0, (state_r != S_IDLE)};

   // read mux and decode
   always @* begin
      rd_word = `PCU_RST_WORD;
      rd_hit = 1'b1;
      if (mem_hit) begin
         rd_word = {16'h0000, mem[paddr_i[9:2]]};
      end else begin
         case (paddr_i)
            `PCU_OFS_CTRL: rd_word = ctrl_word;
            `PCU_OFS_STATUS: rd_word = status_word;
            `PCU_OFS_CVAL: rd_word = cval_r;
            `PCU_OFS_LOWER: rd_word = lower_r;
            `PCU_OFS_UPPER: rd_word = upper_r;
            `PCU_OFS_ADDR: rd_word = {24'h000000, addr_r};
            `PCU_OFS_RESULT: rd_word = {16'h0000, result_r};
            default: rd_hit = 1'b0;
         endcase
      end
   end

   // answer registered one cycle into the access phase
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= `PCU_RST_WORD;
      end else begin
         pready_r <= acc_first;
         pslverr_r <= acc_first && !rd_hit;
         if (acc_first && !pwrite_i) begin
            prdata_r <= rd_word;
         end
      end
   end

   assign prdata_o = prdata_r;
   assign pready_o = pready_r;
   assign pslverr_o = pslverr_r;
   assign above_flag_o = above_r;
   assign same_flag_o = same_r;
   assign below_flag_o = below_r;
   assign fault_flag_o = fault_r;
   assign busy_o = (state_r != S_IDLE);
   assign result_o = result_r;
endmodule

//--- tb/pcu_chk.sv
`timescale 1ns/100ps
`include "pcu_map.vh"
module pcu_chk (
   input wire mclk_i,
   input wire sys_rst_i,
   input wire [11:0] paddr_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [31:0] pwdata_i,
   input wire [31:0] prdata_o,
   input wire pready_o,
   input wire pslverr_o,
   input wire above_flag_o,
   input wire same_flag_o,
   input wire below_flag_o,
   input wire fault_flag_o,
   input wire busy_o,
   input wire [15:0] result_o
);
   reg [2:0] op_r;
   wire [2:0] fl = {above_flag_o, same_flag_o, below_flag_o};
   // start request, exec high or low; go while busy is ignored so it does not count
   wire go = psel_i & penable_i & pready_o & pwrite_i & (paddr_i == `PCU_OFS_CTRL) &
      pwdata_i[0] & !busy_o;
   // opcode of the running op, for judging its completion
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         op_r <= 3'h7;
      end else if (go & pwdata_i[1]) begin
         op_r <= pwdata_i[4:2];
      end
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   a_exec_low_idle: assert property (go & !pwdata_i[1] |=> !busy_o [*3])
      else $error("op started without exec");
   a_go_busy: assert property (go & pwdata_i[1] |=> busy_o)
      else $error("op did not start");
   a_idle_stable: assert property (!busy_o && !$past(busy_o) |->
      $stable({fl, fault_flag_o, result_o})) else $error("outputs moved while idle");
   a_range_onehot: assert property ($fell(busy_o) && op_r >= `PCU_OP_RANGE &&
      op_r <= `PCU_OP_SIGNED && !fault_flag_o |-> $onehot(fl)) else $error("flags not one-hot");
   a_range_time: assert property (go & pwdata_i[1] & !pwdata_i[5] &
      (pwdata_i[4:2] == `PCU_OP_RANGE) |=> busy_o [*3] ##1 !busy_o) else $error("range length");
   a_fault_keeps: assert property ($rose(fault_flag_o) |-> $stable({fl, result_o}))
      else $error("fault changed results");
   a_block_len: assert property ($fell(busy_o) && op_r == `PCU_OP_BLOCK &&
      !fault_flag_o |-> $past(busy_o, 34) && !$past(busy_o, 35)) else $error("block length");
   a_table_len: assert property ($fell(busy_o) && op_r == `PCU_OP_TABLE &&
      !fault_flag_o |-> $past(busy_o, 18) && !$past(busy_o, 19)) else $error("table length");
   a_table_same: assert property ($fell(busy_o) && op_r == `PCU_OP_TABLE &&
      !fault_flag_o |-> same_flag_o == (result_o == 16'h0000)) else $error("table same flag");
   c_block: cover property ($fell(busy_o) && op_r == `PCU_OP_BLOCK && !fault_flag_o);
   c_nomatch: cover property ($fell(busy_o) && op_r == `PCU_OP_TABLE && same_flag_o);
   c_fault: cover property ($rose(fault_flag_o));
endmodule
bind pcu_top pcu_chk u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .paddr_i(paddr_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .above_flag_o(above_flag_o), .same_flag_o(same_flag_o), .below_flag_o(below_flag_o),
   .fault_flag_o(fault_flag_o), .busy_o(busy_o), .result_o(result_o));

//--- tb/tb_plc_compare_unit.sv
`timescale 1ns/100ps
`include "pcu_map.vh"
module tb_plc_compare_unit;
   reg mclk_i = 1'b0;
   reg sys_rst_i = 1'b1;
   reg [11:0] paddr_i = 12'h000;
   reg psel_i = 1'b0;
   reg penable_i = 1'b0;
   reg pwrite_i = 1'b0;
   reg [31:0] pwdata_i = 32'h00000000;
   wire [31:0] prdata_o;
   wire [15:0] result_o;
   wire pready_o, pslverr_o, above_flag_o, same_flag_o, below_flag_o, fault_flag_o, busy_o;
   integer n_mismatch = 0;
   integer checks = 0;
   integer i;
   reg [31:0] rd;
   reg slv;
   reg [15:0] er;
   reg [15:0] lo_a [0:15];
   reg [15:0] up_a [0:15];
   reg [15:0] tb_a [0:15];
   pcu_top DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .paddr_i(paddr_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .above_flag_o(above_flag_o),
      .same_flag_o(same_flag_o), .below_flag_o(below_flag_o), .fault_flag_o(fault_flag_o),
      .busy_o(busy_o), .result_o(result_o));
   always #5 mclk_i = ~mclk_i;
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         checks = checks + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
         end
      end
   endtask
   // one apb transfer; request held until pready is seen high, the watchdog bounds the wait
   task xfer(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge mclk_i);
         paddr_i <= a;
         pwrite_i <= w;
         pwdata_i <= d;
         psel_i <= 1'b1;
         @(posedge mclk_i);
         penable_i <= 1'b1;
         do begin
            @(posedge mclk_i);
         end while (pready_o !== 1'b1);
         rd = prdata_o;
         slv = pslverr_o;
         psel_i <= 1'b0;
         penable_i <= 1'b0;
      end
   endtask
   task mem(input [7:0] a, input [15:0] v);
      xfer(1'b1, {2'h1, a, 2'h0}, {16'h0000, v});
   endtask
   // start an op and wait, bounded, for busy to drop
   task run(input [2:0] op, input ind, input ex);
      integer k;
      begin
         k = 0;
         xfer(1'b1, `PCU_OFS_CTRL, {26'h0, ind, op, ex, 1'b1});
         @(posedge mclk_i);
         while (busy_o !== 1'b0 && k < 100) begin
            @(posedge mclk_i);
            k = k + 1;
         end
         // a unit that never goes idle counts against the run
         if (busy_o !== 1'b0) begin
            n_mismatch = n_mismatch + 1;
         end
      end
   endtask
   // f is below, same, above, fault
   task chk_st(input [3:0] f);
      begin
         xfer(1'b0, `PCU_OFS_STATUS, 32'h0);
         chk("status", {24'h0, f, 4'h0}, rd);
         chk("flag pins", {28'h0, f},
             {28'h0, below_flag_o, same_flag_o, above_flag_o, fault_flag_o});
      end
   endtask
   task chk_res(input [15:0] e);
      begin
         xfer(1'b0, `PCU_OFS_RESULT, 32'h0);
         chk("result reg", {16'h0, e}, rd);
         chk("result pins", {16'h0, e}, {16'h0, result_o});
      end
   endtask
   task rng(input [2:0] op, input [31:0] cv, input [31:0] lo, input [31:0] up, input [3:0] f);
      begin
         xfer(1'b1, `PCU_OFS_CVAL, cv);
         xfer(1'b1, `PCU_OFS_LOWER, lo);
         xfer(1'b1, `PCU_OFS_UPPER, up);
         run(op, 1'b0, 1'b1);
         chk_st(f);
      end
   endtask
   task blk(input [15:0] cv);
      begin
         xfer(1'b1, `PCU_OFS_CVAL, {16'h0, cv});
         run(`PCU_OP_BLOCK, 1'b0, 1'b1);
         for (i = 0; i < 16; i = i + 1) begin
            er[i] = (cv >= lo_a[i]) && (cv <= up_a[i]);
         end
         chk_res(er);
      end
   endtask
   task tbl(input [15:0] cv, input ind);
      begin
         xfer(1'b1, `PCU_OFS_CVAL, {16'h0, cv});
         run(`PCU_OP_TABLE, ind, 1'b1);
         for (i = 0; i < 16; i = i + 1) begin
            er[i] = (cv == tb_a[i]);
         end
         chk_res(er);
         chk_st({1'b0, er == 16'h0000, 2'b00});
      end
   endtask
   task results;
      begin
         $display("mismatches %0d, checks %0d", n_mismatch, checks);
         if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   // watchdog; the whole sequence needs well under a tenth of this
   initial begin
      repeat (40000) @(posedge mclk_i);
      n_mismatch = n_mismatch + 1;
      results;
   end
   initial begin
      repeat (20) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      chk_st(4'h0);
      xfer(1'b0, 12'h01C, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, slv});
      rng(`PCU_OP_RANGE, 32'h000F, 32'h0010, 32'hAB1F, 4'h8);
      rng(`PCU_OP_RANGE, 32'h0010, 32'h0010, 32'hAB1F, 4'h4);
      rng(`PCU_OP_RANGE, 32'hAB1F, 32'h0010, 32'hAB1F, 4'h4);
      rng(`PCU_OP_RANGE, 32'hAB20, 32'h0010, 32'hAB1F, 4'h2);
      xfer(1'b1, `PCU_OFS_CVAL, 32'h000F);
      run(`PCU_OP_RANGE, 1'b0, 1'b0);
      chk_st(4'h2);
      rng(`PCU_OP_RANGE, 32'h0005, 32'h0011, 32'h0010, 4'h3);
      rng(`PCU_OP_DRANGE, 32'h0000FFFF, 32'h00010000, 32'h00020000, 4'h8);
      rng(`PCU_OP_DRANGE, 32'h00018000, 32'h00010000, 32'h00020000, 4'h4);
      rng(`PCU_OP_DRANGE, 32'h00020001, 32'h00010000, 32'h00020000, 4'h2);
      rng(`PCU_OP_SIGNED, 32'hFFFF, 32'h0, 32'h0001, 4'h8);
      rng(`PCU_OP_SIGNED, 32'h7FFF, 32'h0, 32'h8000, 4'h2);
      rng(`PCU_OP_SIGNED, 32'h8000, 32'h0, 32'h8000, 4'h4);
      // limit pairs abut, so each value falls in at most one pair
      for (i = 0; i < 16; i = i + 1) begin
         lo_a[i] = (i == 0) ? 16'h0000 : i * 256 + 1;
         up_a[i] = (i + 1) * 256;
         tb_a[i] = (i % 4 == 2) ? 16'h0210 : i * 256 + 256;
         mem(8'h10 + 2 * i, lo_a[i]);
         mem(8'h11 + 2 * i, up_a[i]);
         mem(8'h40 + i, tb_a[i]);
         // top of the area holds empty pairs for the edge-of-area block
         mem(8'hE0 + 2 * i, 16'h0000);
         mem(8'hE1 + 2 * i, 16'h0000);
      end
      xfer(1'b1, `PCU_OFS_ADDR, 32'h10);
      blk(16'h0000);
      blk(16'h1601);
      blk(16'h0301);
      blk(16'h0210);
      blk(16'h0300);
      xfer(1'b1, `PCU_OFS_ADDR, 32'hE1);
      run(`PCU_OP_BLOCK, 1'b0, 1'b1);
      chk_st(4'h5);
      chk_res(16'h0004);
      xfer(1'b1, `PCU_OFS_ADDR, 32'hE0);
      run(`PCU_OP_BLOCK, 1'b0, 1'b1);
      chk_st(4'h4);
      chk_res(16'h0000);
      xfer(1'b1, `PCU_OFS_ADDR, 32'h40);
      tbl(16'h0210, 1'b0);
      tbl(16'h0300, 1'b0);
      tbl(16'h0100, 1'b0);
      tbl(16'h1000, 1'b0);
      xfer(1'b1, `PCU_OFS_ADDR, 32'hF1);
      run(`PCU_OP_TABLE, 1'b0, 1'b1);
      chk_st(4'h1);
      chk_res(16'h8000);
      mem(8'h05, 16'h0064);
      xfer(1'b1, `PCU_OFS_ADDR, 32'h05);
      tbl(16'h0210, 1'b1);
      mem(8'h05, 16'h00A0);
      run(`PCU_OP_TABLE, 1'b1, 1'b1);
      chk_st(4'h1);
      mem(8'h05, 16'h0256);
      run(`PCU_OP_RANGE, 1'b1, 1'b1);
      chk_st(4'h1);
      chk_res(16'h4444);
      // valid pointers: word 0064 resolves to 0x40, word 0016 to 0x10
      mem(8'h05, 16'h0064);
      xfer(1'b1, `PCU_OFS_LOWER, 32'h0101);
      xfer(1'b1, `PCU_OFS_UPPER, 32'h0200);
      run(`PCU_OP_RANGE, 1'b1, 1'b1);
      chk_st(4'h8);
      run(`PCU_OP_DRANGE, 1'b1, 1'b1);
      chk_st(4'h2);
      run(`PCU_OP_SIGNED, 1'b1, 1'b1);
      chk_st(4'h8);
      mem(8'h05, 16'h0016);
      run(`PCU_OP_BLOCK, 1'b1, 1'b1);
      chk_res(16'h0004);
      run(3'h5, 1'b0, 1'b1);
      chk_st(4'h9);
      results;
   end
endmodule
